// ==== spu_pkg.sv ====
// Purpose: shared constants and encodings of the serial port block
// Assumes: 32-bit classic wishbone, word index = byte address / 4
// Notes:   oversampling runs at sixteen ticks per asynchronous bit
package spu_pkg;

  // ***************************************************************
  // register map, word indices
  // ***************************************************************
  localparam int          ADR_W     = 12;
  localparam int          IDX_W     = 10;
  localparam logic [9:0]  IDX_CTRL  = 10'h098;  // serial_control
  localparam logic [9:0]  IDX_DATA  = 10'h099;  // serial_data_buffer
  localparam logic [9:0]  IDX_PWR   = 10'h09a;  // power_control_register
  localparam logic [9:0]  IDX_ISTAT = 10'h09b;  // sticky event status, read only
  localparam logic [9:0]  IDX_ICLR  = 10'h09c;  // write one to clear, write only
  localparam logic [9:0]  IDX_IEN   = 10'h09d;  // event enable

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CB_SM0 = 7;
  localparam int CB_SM1 = 6;
  localparam int CB_SM2 = 5;
  localparam int CB_REN = 4;
  localparam int CB_TB8 = 3;
  localparam int CB_RB8 = 2;
  localparam int CB_TI  = 1;
  localparam int CB_RI  = 0;
  localparam int PB_DBL = 7;   // mode 2 rate: clock / 32 when set
  localparam int PB_FCS = 6;   // frame_check_select
  localparam int IB_TX  = 0;
  localparam int IB_RX  = 1;
  localparam int IB_FE  = 2;
  localparam int IRQ_W  = 3;

  // ***************************************************************
  // modes and timing
  // ***************************************************************
  typedef enum logic [1:0] {
    SPU_MODE0 = 2'b00,
    SPU_MODE1 = 2'b01,
    SPU_MODE2 = 2'b10,
    SPU_MODE3 = 2'b11
  } spu_mode_t;

  localparam logic [2:0] M0_HALF_SLOW = 3'h6;  // half of clock / 12
  localparam logic [2:0] M0_HALF_FAST = 3'h2;  // half of clock / 4
  localparam logic [2:0] M2_SUB_SLOW  = 3'h4;  // clock / 64 over 16 ticks
  localparam logic [2:0] M2_SUB_FAST  = 3'h2;  // clock / 32 over 16 ticks
  localparam logic [3:0] OVS_MID      = 4'h7;
  localparam logic [3:0] OVS_LAST     = 4'hf;
  localparam logic [3:0] TX_BITS_10   = 4'ha;
  localparam logic [3:0] TX_BITS_11   = 4'hb;
  localparam logic [3:0] RX_BITS_M1   = 4'h9;  // data plus stop
  localparam logic [3:0] RX_BITS_M23  = 4'ha;  // data, ninth, stop
  localparam logic [3:0] M0_BITS      = 4'h8;
  localparam logic       LINE_IDLE    = 1'b1;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SYNC  = 2'b10
  } spu_tx_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_SYNC  = 2'b11
  } spu_rx_t;

endpackage

// ==== spu_bitgen.sv ====
// Purpose: tick generator for the serial port
// Assumes: timer overflow arrives as a one-cycle pulse
// Notes:   mode 0 ticks each half shift clock, others sixteen per bit
`timescale 1ns/100ps
module spu_bitgen (
  input  wire logic        clk,       // oscillator clock
  input  wire logic        reset,     // sync, active high
  input  wire logic [1:0]  mode,      // current serial mode
  input  wire logic        fast,      // mode 0 rate select
  input  wire logic        dbl,       // mode 2 rate select
  input  wire logic        tmr_ovf,   // timer overflow pulse
  output logic             tick       // one-cycle tick
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } spu_bg_t;

  spu_bg_t     st_r;
  spu_bg_t     st_nxt;
  logic [2:0]  lim;

  // ***************************************************************
  // divider
  // ***************************************************************
  // pick the divide ratio, then count up to it for a tick
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    lim = (spu_pkg::spu_mode_t'(mode) == spu_pkg::SPU_MODE0)
        ? (fast ? spu_pkg::M0_HALF_FAST : spu_pkg::M0_HALF_SLOW)   // [RQ6]
        : (dbl ? spu_pkg::M2_SUB_FAST : spu_pkg::M2_SUB_SLOW);
    unique case (spu_pkg::spu_mode_t'(mode))
      spu_pkg::SPU_MODE1, spu_pkg::SPU_MODE3: begin
        st_nxt.tick = tmr_ovf;   // variable rate from the timer [RQ14]
        st_nxt.cnt  = '0;
      end
      spu_pkg::SPU_MODE0, spu_pkg::SPU_MODE2: begin
        if (st_r.cnt >= lim - 3'h1) begin
          st_nxt.cnt  = '0;
          st_nxt.tick = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 3'h1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

// ==== spu_top.sv ====
// Purpose: full-duplex serial port with wishbone register access
// Assumes: pins synchronous to CLK, CLK is the oscillator clock
// Notes:   a data write while the transmitter is busy is dropped
`timescale 1ns/100ps
// Operation
// RQ1: power-control bit picks mode bit or error flag at control bit 7
// RQ2: a bad stop bit sets the framing error flag until software clears it
// RQ3: modes: sync 8-bit, async 10-bit, async 11-bit fixed or variable rate
// RQ4: modes 2, 3 with filter set drop frames with ninth bit 0
// RQ5: mode 1 with filter set drops frames with a bad stop bit
// RQ6: mode 0 shift clock is clock / 12, or clock / 4 with filter set
// RQ7: reception only while receive enable is 1
// RQ8: modes 2, 3 send the software ninth bit as ninth frame bit
// RQ9: received ninth bit: bit 9 in modes 2, 3, stop bit in mode 1
// RQ10: transmit done: after bit 8 in mode 0, at stop start otherwise
// RQ11: receive done: after bit 8 in mode 0, mid stop bit otherwise
// RQ12: data reads return the receive register, writes load the transmit buffer
// RQ13: a data write starts a frame, lsb first
// RQ14: modes 1, 3 take bit rate from the timer overflow pulse
module spu_top #(
  parameter int DW = 32
) (
  input  wire logic                     CLK,        // oscillator clock
  input  wire logic                     RESET,      // sync, active high
  input  wire logic                     CYC_I,      // wishbone cycle
  input  wire logic                     STB_I,      // wishbone strobe
  input  wire logic                     WE_I,       // write enable
  input  wire logic [spu_pkg::ADR_W-1:0] ADR_I,     // byte address
  input  wire logic [DW-1:0]            DAT_I,      // write data
  input  wire logic [DW/8-1:0]          SEL_I,      // byte selects
  output logic      [DW-1:0]            DAT_O,      // read data
  output logic                          ACK_O,      // acknowledge
  input  wire logic                     TIMER_OVF,  // rate pulse
  output logic                          TXD,        // serial out / shift clock
  input  wire logic                     RXD_I,      // serial data in
  output logic                          RXD_O,      // mode 0 data out
  output logic                          RXD_OE_N,   // low while driving
  output logic                          IRQ         // level interrupt
);

  typedef struct packed {
    logic                     sm0;
    logic                     sm1;
    logic                     sm2;
    logic                     ren;
    logic                     tb8;
    logic                     rb8;
    logic                     ti;
    logic                     ri;
    logic                     fe;
    logic                     fcs;
    logic                     dbl;
    logic [7:0]               rxbuf;
    logic                     ack;
    logic [DW-1:0]            dato;
    logic [spu_pkg::IRQ_W-1:0] istat;
    logic [spu_pkg::IRQ_W-1:0] ien;
    logic                     irq;
    logic                     txd;
    logic                     rxd_o;
    logic                     rxd_oe_n;
    logic                     rxd_prev;
    logic                     ph;
    spu_pkg::spu_tx_t         tx_st;
    logic [10:0]              tx_sh;
    logic [3:0]               tx_cnt;
    logic [3:0]               tx_sub;
    spu_pkg::spu_rx_t         rx_st;
    logic [9:0]               rx_sh;
    logic [3:0]               rx_cnt;
    logic [3:0]               rx_sub;
  } spu_state_t;

  spu_state_t         st_r;
  spu_state_t         st_nxt;
  logic               tick;
  spu_pkg::spu_mode_t mode;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // word index from a byte address, used by read and write decode
  function automatic logic [spu_pkg::IDX_W-1:0] word_idx(input logic [spu_pkg::ADR_W-1:0] a);
    return a[spu_pkg::ADR_W-1:2];
  endfunction

  // software view of the control register
  function automatic logic [7:0] ctrl_view(input spu_state_t s);
    logic b7;
    b7 = s.fcs ? s.fe : s.sm0;   // [RQ1]
    return {b7, s.sm1, s.sm2, s.ren, s.tb8, s.rb8, s.ti, s.ri};
  endfunction

  assign mode = spu_pkg::spu_mode_t'({st_r.sm0, st_r.sm1});   // [RQ3]

  // ***************************************************************
  // tick generator
  // ***************************************************************
  spu_bitgen u_bitgen (
    .clk     (CLK),
    .reset   (RESET),
    .mode    (mode),
    .fast    (st_r.sm2),
    .dbl     (st_r.dbl),
    .tmr_ovf (TIMER_OVF),
    .tick    (tick)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  // bus writes first, hardware sets afterwards so a set always wins
  always_comb begin
    logic                      wr;
    logic [spu_pkg::IDX_W-1:0] idx;
    logic [7:0]                rdv;
    logic [7:0]                wd;
    logic [spu_pkg::IRQ_W-1:0] ev;
    logic [spu_pkg::IRQ_W-1:0] clr;
    logic                      tx_go;
    logic                      m23;
    logic [9:0]                nsh;
    logic                      stop;
    logic                      ninth;
    logic [7:0]                rdat;
    logic                      take;
    wr    = 1'b0;
    idx   = '0;
    rdv   = '0;
    wd    = '0;
    ev    = '0;
    clr   = '0;
    tx_go = 1'b0;
    m23   = 1'b0;
    nsh   = '0;
    stop  = 1'b0;
    ninth = 1'b0;
    rdat  = '0;
    take  = 1'b0;
    st_nxt = st_r;
    idx = word_idx(ADR_I);
    wd  = DAT_I[7:0];
    m23 = (mode == spu_pkg::SPU_MODE2) || (mode == spu_pkg::SPU_MODE3);

    // one wait state: ack rises the cycle after the strobe, read data with it
    st_nxt.ack = CYC_I & STB_I & ~st_r.ack;
    wr = CYC_I & STB_I & st_r.ack & WE_I & SEL_I[0];
    unique case (idx)
      spu_pkg::IDX_CTRL:  rdv = ctrl_view(st_r);
      spu_pkg::IDX_DATA:  rdv = st_r.rxbuf;   // reads see the receive side [RQ12]
      spu_pkg::IDX_PWR:   rdv = {st_r.dbl, st_r.fcs, 6'h00};
      spu_pkg::IDX_ISTAT: rdv = {{(8-spu_pkg::IRQ_W){1'b0}}, st_r.istat};
      spu_pkg::IDX_IEN:   rdv = {{(8-spu_pkg::IRQ_W){1'b0}}, st_r.ien};
      default:            rdv = '0;   // unmapped and write-only read as zero
    endcase
    if (st_nxt.ack) begin
      st_nxt.dato = {{(DW-8){1'b0}}, rdv};
    end

    // register writes
    if (wr) begin
      unique case (idx)
        spu_pkg::IDX_CTRL: begin
          if (st_r.fcs) begin
            st_nxt.fe = wd[spu_pkg::CB_SM0];   // software clears the flag [RQ2]
          end else begin
            st_nxt.sm0 = wd[spu_pkg::CB_SM0];   // [RQ1]
          end
          st_nxt.sm1 = wd[spu_pkg::CB_SM1];
          st_nxt.sm2 = wd[spu_pkg::CB_SM2];
          st_nxt.ren = wd[spu_pkg::CB_REN];
          st_nxt.tb8 = wd[spu_pkg::CB_TB8];
          st_nxt.rb8 = wd[spu_pkg::CB_RB8];
          st_nxt.ti  = wd[spu_pkg::CB_TI];   // [RQ10]
          st_nxt.ri  = wd[spu_pkg::CB_RI];   // [RQ11]
        end
        spu_pkg::IDX_DATA: tx_go = (st_r.tx_st == spu_pkg::TX_IDLE)
                                 && (st_r.rx_st != spu_pkg::RX_SYNC);   // [RQ12]
        spu_pkg::IDX_PWR: begin
          st_nxt.dbl = wd[spu_pkg::PB_DBL];
          st_nxt.fcs = wd[spu_pkg::PB_FCS];   // [RQ1]
        end
        spu_pkg::IDX_ICLR: clr = wd[spu_pkg::IRQ_W-1:0];
        spu_pkg::IDX_IEN:  st_nxt.ien = wd[spu_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    // ***************************************************************
    // transmitter
    // ***************************************************************
    // shift register drains low bit first, ones fill from the top
    unique case (st_r.tx_st)
      spu_pkg::TX_IDLE: begin
        if (tx_go && mode == spu_pkg::SPU_MODE0) begin
          st_nxt.tx_sh  = {3'b111, wd};   // [RQ13]
          st_nxt.tx_cnt = spu_pkg::M0_BITS;
          st_nxt.ph     = 1'b0;
          st_nxt.tx_st  = spu_pkg::TX_SYNC;
        end else if (tx_go) begin
          // start bit leaves at once, ninth bit from software [RQ8]
          st_nxt.tx_sh  = {1'b1, (m23 ? st_r.tb8 : 1'b1), wd, 1'b0};   // [RQ13]
          st_nxt.tx_cnt = m23 ? spu_pkg::TX_BITS_11 : spu_pkg::TX_BITS_10;   // [RQ3]
          st_nxt.tx_sub = '0;
          st_nxt.txd    = 1'b0;
          st_nxt.tx_st  = spu_pkg::TX_ASYNC;
        end
      end
      spu_pkg::TX_ASYNC: begin
        if (tick && st_r.tx_sub == spu_pkg::OVS_LAST) begin
          st_nxt.tx_sub = '0;
          if (st_r.tx_cnt == 4'h1) begin
            st_nxt.txd   = spu_pkg::LINE_IDLE;
            st_nxt.tx_st = spu_pkg::TX_IDLE;
          end else begin
            st_nxt.tx_sh  = {1'b1, st_r.tx_sh[10:1]};
            st_nxt.txd    = st_r.tx_sh[1];
            st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
            if (st_r.tx_cnt == 4'h2) begin
              ev[spu_pkg::IB_TX] = 1'b1;   // stop bit begins [RQ10]
            end
          end
        end else if (tick) begin
          st_nxt.tx_sub = st_r.tx_sub + 4'h1;
        end
      end
      spu_pkg::TX_SYNC: begin
        // data changes with the falling shift clock, peer samples on rise
        if (tick && !st_r.ph) begin
          st_nxt.txd      = 1'b0;
          st_nxt.rxd_o    = st_r.tx_sh[0];
          st_nxt.rxd_oe_n = 1'b0;
          st_nxt.ph       = 1'b1;
        end else if (tick) begin
          st_nxt.txd    = 1'b1;
          st_nxt.tx_sh  = {1'b1, st_r.tx_sh[10:1]};
          st_nxt.ph     = 1'b0;
          st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
          if (st_r.tx_cnt == 4'h1) begin
            ev[spu_pkg::IB_TX] = 1'b1;   // end of bit 8 [RQ10]
            st_nxt.rxd_oe_n    = 1'b1;
            st_nxt.tx_st       = spu_pkg::TX_IDLE;
          end
        end
      end
      default: st_nxt.tx_st = spu_pkg::TX_IDLE;
    endcase

    // ***************************************************************
    // receiver
    // ***************************************************************
    // single sample at mid bit; no majority vote, so noise is not filtered
    st_nxt.rxd_prev = RXD_I;
    unique case (st_r.rx_st)
      spu_pkg::RX_IDLE: begin
        if (st_r.ren && mode == spu_pkg::SPU_MODE0 && !st_r.ri
            && st_r.tx_st == spu_pkg::TX_IDLE && !tx_go) begin   // [RQ7]
          st_nxt.rx_cnt = spu_pkg::M0_BITS;
          st_nxt.ph     = 1'b0;
          st_nxt.rx_st  = spu_pkg::RX_SYNC;
        end else if (st_r.ren && mode != spu_pkg::SPU_MODE0
                     && st_r.rxd_prev && !RXD_I) begin   // [RQ7]
          st_nxt.rx_sub = '0;
          st_nxt.rx_st  = spu_pkg::RX_START;
        end
      end
      spu_pkg::RX_START: begin
        if (!st_r.ren) begin
          st_nxt.rx_st = spu_pkg::RX_IDLE;   // [RQ7]
        end else if (tick && st_r.rx_sub == spu_pkg::OVS_MID) begin
          // a start bit gone high by mid bit was a glitch
          st_nxt.rx_sub = '0;
          st_nxt.rx_cnt = m23 ? spu_pkg::RX_BITS_M23 : spu_pkg::RX_BITS_M1;
          st_nxt.rx_st  = RXD_I ? spu_pkg::RX_IDLE : spu_pkg::RX_DATA;
        end else if (tick) begin
          st_nxt.rx_sub = st_r.rx_sub + 4'h1;
        end
      end
      spu_pkg::RX_DATA: begin
        if (!st_r.ren) begin
          st_nxt.rx_st = spu_pkg::RX_IDLE;   // [RQ7]
        end else if (tick && st_r.rx_sub == spu_pkg::OVS_LAST) begin
          nsh = {RXD_I, st_r.rx_sh[9:1]};
          st_nxt.rx_sub = '0;
          st_nxt.rx_sh  = nsh;
          st_nxt.rx_cnt = st_r.rx_cnt - 4'h1;
          if (st_r.rx_cnt == 4'h1) begin
            // this sample is the middle of the stop bit [RQ11]
            stop  = nsh[9];
            ninth = m23 ? nsh[8] : nsh[9];   // [RQ9]
            rdat  = m23 ? nsh[7:0] : nsh[8:1];
            take  = !st_r.ri && (!st_r.sm2 || (m23 ? ninth : stop));   // [RQ4] [RQ5]
            if (!stop) begin
              st_nxt.fe          = 1'b1;   // [RQ2]
              ev[spu_pkg::IB_FE] = 1'b1;
            end
            if (take) begin
              st_nxt.rxbuf       = rdat;
              st_nxt.rb8         = ninth;   // [RQ9]
              st_nxt.ri          = 1'b1;   // [RQ11]
              ev[spu_pkg::IB_RX] = 1'b1;
            end
            st_nxt.rx_st = spu_pkg::RX_IDLE;
          end
        end else if (tick) begin
          st_nxt.rx_sub = st_r.rx_sub + 4'h1;
        end
      end
      spu_pkg::RX_SYNC: begin
        // device drives the shift clock, samples on its rising edge
        if (!st_r.ren) begin
          st_nxt.txd   = 1'b1;
          st_nxt.rx_st = spu_pkg::RX_IDLE;   // [RQ7]
        end else if (tick && !st_r.ph) begin
          st_nxt.txd = 1'b0;
          st_nxt.ph  = 1'b1;
        end else if (tick) begin
          st_nxt.txd    = 1'b1;
          st_nxt.ph     = 1'b0;
          st_nxt.rx_sh  = {RXD_I, st_r.rx_sh[9:1]};
          st_nxt.rx_cnt = st_r.rx_cnt - 4'h1;
          if (st_r.rx_cnt == 4'h1) begin
            st_nxt.rxbuf       = {RXD_I, st_r.rx_sh[9:3]};
            st_nxt.ri          = 1'b1;   // end of bit 8 [RQ11]
            ev[spu_pkg::IB_RX] = 1'b1;
            st_nxt.rx_st       = spu_pkg::RX_IDLE;
          end
        end
      end
    endcase

    // ***************************************************************
    // flags and interrupt
    // ***************************************************************
    // an event in the clearing cycle stays set
    if (ev[spu_pkg::IB_TX]) begin
      st_nxt.ti = 1'b1;   // [RQ10]
    end
    st_nxt.istat = (st_r.istat & ~clr) | ev;
    st_nxt.irq   = |(st_nxt.istat & st_nxt.ien);
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // idle line high and data pin released out of reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r          <= '0;
      st_r.txd      <= spu_pkg::LINE_IDLE;
      st_r.rxd_o    <= spu_pkg::LINE_IDLE;
      st_r.rxd_oe_n <= 1'b1;
      st_r.rxd_prev <= spu_pkg::LINE_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign DAT_O    = st_r.dato;
  assign ACK_O    = st_r.ack;
  assign TXD      = st_r.txd;
  assign RXD_O    = st_r.rxd_o;
  assign RXD_OE_N = st_r.rxd_oe_n;
  assign IRQ      = st_r.irq;

endmodule

// ==== spu_sva.sv ====
// Purpose: concurrent checks on the serial port bus and pins
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/100ps
module spu_sva #(
  parameter int DW = 32
) (
  input wire logic                      CLK,      // clock
  input wire logic                      RESET,    // reset
  input wire logic                      CYC_I,    // cycle
  input wire logic                      STB_I,    // strobe
  input wire logic                      WE_I,     // write
  input wire logic [spu_pkg::ADR_W-1:0] ADR_I,    // byte address
  input wire logic [DW-1:0]             DAT_O,    // read data
  input wire logic                      ACK_O,    // ack
  input wire logic                      TXD,      // out or shift clock
  input wire logic                      RXD_O,    // shift data
  input wire logic                      RXD_OE_N, // drive enable
  input wire logic                      IRQ       // interrupt
);
  logic [spu_pkg::IDX_W-1:0] idx;

  // word index of the access
  assign idx = ADR_I[11:2];
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // bus answers: one wait cycle, one-cycle ack, upper lanes quiet
  a_ack_one_wait: assert property ($rose(CYC_I && STB_I) |=> ACK_O)
    else $error("ack late");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  a_ack_has_req: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("stray ack");
  a_read_high_zero: assert property (ACK_O |-> DAT_O[DW-1:8] == '0)
    else $error("upper lanes");
  a_unmapped_zero: assert property (ACK_O && !WE_I && (idx < spu_pkg::IDX_CTRL ||
    idx > spu_pkg::IDX_IEN) |-> DAT_O == '0)
    else $error("unmapped read");
  // pins leave reset idle, no interrupt pending
  a_reset_idle: assert property ($fell(RESET) |-> TXD && RXD_O && RXD_OE_N && !IRQ)
    else $error("pins not idle");
  // shift clock low phase is 2 or 6 clocks, data steady across the rise
  a_m0_low_width: assert property ($fell(TXD) && !RXD_OE_N |-> !TXD ##1 !TXD ##[1:5] TXD)
    else $error("low phase width");
  a_m0_data_hold: assert property (!RXD_OE_N && $rose(TXD) |-> $stable(RXD_O))
    else $error("data moved");
endmodule

bind spu_top spu_sva #(.DW(DW)) spu_sva_inst (.*);

// ==== spu_peer.sv ====
// Purpose: remote serial peer sending asynchronous frames
// Assumes: the line has a pull-up, so it idles high
// Notes:   sends exactly the bits given, bad stop bits included
`timescale 1ns/100ps
module spu_peer (
  input  wire logic        clk,   // bench clock
  input  wire logic        go,    // start a frame
  input  wire logic [10:0] bits,  // start bit first, lsb first
  input  wire logic [7:0]  nb,    // bits in the frame
  input  wire logic [7:0]  per,   // clocks per bit
  output logic             line,  // serial line
  output logic             busy   // frame in flight
);
  // frames go out whole; the released line returns to the pull-up level
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < nb; i++) begin
          line <= bits[i];
          repeat (per) @(posedge clk);
        end
        line <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule

// ==== serial_port_uart_tb_top.sv ====
// Purpose: self-checking bench for the serial port block
// Assumes: rate pulse every 2 clocks, so mode 1 and 3 bits last 32 clocks, mode 2 bits 64
// Notes:   expectations are worked out here, never read back
`timescale 1ns/100ps
module serial_port_uart_tb_top;
  logic        CLK, RESET, CYC_I, STB_I, WE_I, TIMER_OVF, go, busy;
  logic        ACK_O, TXD, RXD_O, RXD_OE_N, IRQ, peer_line;
  logic [11:0] ADR_I;
  logic [31:0] DAT_I, DAT_O, rd, rnd;
  logic [10:0] fbits;
  logic [7:0]  d, nbits, per;
  logic [3:0]  SEL_I;
  wire         rxd_pin;
  int          err_total, checked, cycles;
  int          cv[6] = '{8'h50, 8'h50, 8'h70, 8'hf0, 8'hf0, 8'h40};
  int          hv[6] = '{8'h1, 8'h0, 8'h0, 8'h2, 8'h3, 8'h1};
  int          ev[6] = '{8'h3, 8'h5, 8'h4, 8'h0, 8'h3, 8'h0};
  logic [9:0]  ridx[6] = '{10'h098, 10'h099, 10'h09a, 10'h09b, 10'h09d, 10'h0a0};

  // shift data owns the pin while its enable is low, else the peer
  assign rxd_pin = RXD_OE_N ? peer_line : RXD_O;
  spu_top spu_top_inst (.CLK(CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .TIMER_OVF(TIMER_OVF), .TXD(TXD), .RXD_I(rxd_pin), .RXD_O(RXD_O),
    .RXD_OE_N(RXD_OE_N), .IRQ(IRQ));
  spu_peer spu_peer_inst (.clk(CLK), .go(go), .bits(fbits), .nb(nbits), .per(per),
    .line(peer_line), .busy(busy));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // rate pulse every second clock; hang guard
  always @(posedge CLK) begin
    TIMER_OVF <= ~TIMER_OVF;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      finish_test;
    end
  end

  function automatic logic [7:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[7:0];
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: %s, seen %h expected %h", $time, w, s, e);
    end
  endtask
  // one classic cycle; waits for ack, never assumes a latency
  task automatic wb(input logic we, input logic [9:0] i, input logic [7:0] wd);
    int n = 0;
    @(posedge CLK);
    {CYC_I, STB_I, WE_I} <= {2'b11, we};
    ADR_I <= {i, 2'b00};
    DAT_I <= {24'h0, wd};
    SEL_I <= 4'hf;
    do begin
      @(posedge CLK);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    rd = DAT_O;
    chk(n < 50, 1'b1, "bus ack");
    {CYC_I, STB_I} <= 2'b00;
  endtask
  task automatic wait_lvl(input logic v);
    int n = 0;
    while (TXD !== v && n < 2000) begin
      @(posedge CLK);
      n++;
    end
  endtask
  // samples each async bit at its middle, with the interrupt beside it
  task automatic tx_chk(input logic [10:0] b, input int nb, input int p);
    wait_lvl(1'b0);
    repeat (p / 2) @(posedge CLK);
    for (int i = 0; i < nb; i++) begin
      chk(TXD, b[i], "tx bit");
      chk(IRQ, i == nb - 1, "tx done");
      repeat (p) @(posedge CLK);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {RESET, CYC_I, STB_I, WE_I, go, TIMER_OVF} = 6'h20;
    {ADR_I, DAT_I, SEL_I, fbits} = '0;
    {nbits, per, rnd} = {8'h0a, 8'h20, 32'h97d6};
    {err_total, checked, cycles} = '0;
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    foreach (ridx[k]) begin
      wb(1'b0, ridx[k], 8'h00);
      chk(rd, 32'h0, "reset");
    end
    $display("registers done");
    wb(1'b1, spu_pkg::IDX_IEN, 8'h01);
    for (int m = 1; m < 4; m++) begin
      d = xs();
      wb(1'b1, spu_pkg::IDX_ICLR, 8'h07);
      wb(1'b1, spu_pkg::IDX_CTRL, {m[1:0], 2'b00, rnd[9], 3'b000});
      wb(1'b1, spu_pkg::IDX_DATA, d);
      fbits = (m == 1) ? {2'b01, d, 1'b0} : {1'b1, rnd[9], d, 1'b0};
      tx_chk(fbits, (m == 1) ? 10 : 11, (m == 2) ? 64 : 32);
      wb(1'b0, spu_pkg::IDX_DATA, 8'h00);
      chk(rd, 32'h0, "rx side");
    end
    $display("async tx done");
    for (int k = 0; k < 2; k++) begin
      d = xs();
      wb(1'b1, spu_pkg::IDX_CTRL, k ? 8'h20 : 8'h00);
      wb(1'b1, spu_pkg::IDX_DATA, d);
      for (int i = 0; i < 8; i++) begin
        wait_lvl(1'b0);
        for (int n = 0; n < 8; n++) begin
          @(posedge CLK);
          if (TXD === 1'b1) begin
            chk(n + 1, k ? 2 : 6, "low phase");
            break;
          end
        end
        chk(RXD_O, d[i], "shift bit");
      end
      repeat (4) @(posedge CLK);
      wb(1'b0, spu_pkg::IDX_CTRL, 8'h00);
      chk(rd, k ? 32'h22 : 32'h02, "shift done");
    end
    $display("shift mode done");
    for (int k = 0; k < 6; k++) begin
      d = xs();
      wb(1'b1, spu_pkg::IDX_CTRL, cv[k][7:0]);
      wb(1'b1, spu_pkg::IDX_ICLR, 8'h07);
      fbits <= {hv[k][1:0], d, 1'b0};
      nbits <= cv[k][7] ? 8'h0b : 8'h0a;
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      do @(posedge CLK); while (busy === 1'b1);
      repeat (2) @(posedge CLK);
      wb(1'b0, spu_pkg::IDX_CTRL, 8'h00);
      chk(rd[0], ev[k][0], "rx done");
      if (ev[k][0]) begin
        chk(rd[2], ev[k][1], "ninth");
        wb(1'b0, spu_pkg::IDX_DATA, 8'h00);
        chk(rd, {24'h0, d}, "rx byte");
      end
      wb(1'b0, spu_pkg::IDX_ISTAT, 8'h00);
      chk(rd[2:1], {ev[k][2], ev[k][0]}, "status");
    end
    wb(1'b0, spu_pkg::IDX_CTRL, 8'h00);
    chk(rd[7], 1'b0, "bit7 mode");
    wb(1'b1, spu_pkg::IDX_PWR, 8'h40);
    wb(1'b0, spu_pkg::IDX_CTRL, 8'h00);
    chk(rd[7], 1'b1, "bit7 error");
    wb(1'b1, spu_pkg::IDX_CTRL, 8'h40);
    wb(1'b0, spu_pkg::IDX_CTRL, 8'h00);
    chk(rd[7], 1'b0, "error cleared");
    $display("receive done");
    wb(1'b1, spu_pkg::IDX_IEN, 8'h00);
    wb(1'b1, spu_pkg::IDX_ICLR, 8'h07);
    wb(1'b1, spu_pkg::IDX_DATA, xs());
    repeat (400) @(posedge CLK);
    chk(IRQ, 1'b0, "masked irq");
    wb(1'b1, spu_pkg::IDX_ISTAT, 8'h00);
    wb(1'b0, spu_pkg::IDX_ISTAT, 8'h00);
    chk(rd, 32'h1, "sticky tx");
    wb(1'b1, spu_pkg::IDX_IEN, 8'h01);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b1, "irq on");
    wb(1'b1, spu_pkg::IDX_ICLR, 8'h01);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0, "irq off");
    $display("interrupt done");
    finish_test;
  end
endmodule
